// ==== verilog/timer_unit_pkg.sv ====
// Purpose: Shared constants for the timer unit: register map, field layout, resets, modes.
// Assumes: 32-bit APB data, 12-bit byte address, one word per register.
// Notes: Slice registers live on a page of their own, one 32-byte stride per slice.
package timer_unit_pkg;

  // ----------------------------------------------------------------
  // Global register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] GLOBAL_CTRL_OFS = 12'h000;
  localparam logic [11:0] IRQ_STATUS_OFS = 12'h004;
  localparam logic [11:0] IRQ_CLEAR_OFS = 12'h008;
  localparam logic [11:0] IRQ_ENABLE_OFS = 12'h00C;
  localparam logic [11:0] SHARED_READ_OFS = 12'h010;

  // ----------------------------------------------------------------
  // Slice page: paddr[11:8] selects page, [7:5] slice, [4:2] word
  // ----------------------------------------------------------------
  localparam logic [3:0] SLICE_PAGE = 4'h1;
  localparam logic [2:0] SL_CTRL = 3'h0;
  localparam logic [2:0] SL_PERIOD = 3'h1;
  localparam logic [2:0] SL_COMPARE = 3'h2;
  localparam logic [2:0] SL_DITHER = 3'h3;
  localparam logic [2:0] SL_TIMER = 3'h4;
  localparam logic [2:0] SL_FULL = 3'h5;

  // ----------------------------------------------------------------
  // Slice control field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ECM = 1;
  localparam int CTRL_CAP0 = 2;
  localparam int CTRL_CAP1 = 4;
  localparam int CTRL_CNT_EXT = 6;
  localparam int CTRL_DITH = 7;
  localparam int CTRL_PRESCALER_SELECT = 9;
  localparam int CTRL_IRQEN = 13;
  localparam int CTRL_ROUTE = 16;
  localparam logic [31:0] CTRL_MASK = 32'h003F_FFFF;

  // ----------------------------------------------------------------
  // Reset values and widths
  // ----------------------------------------------------------------
  localparam int TIMER_W = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [3:0] DITHER_RESET = 4'h0;
  localparam logic [31:0] IRQ_ENABLE_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Shared read word layout
  // ----------------------------------------------------------------
  localparam int SR_REG_POS = 16;
  localparam int SR_SLICE_POS = 20;
  localparam int SR_VALID_POS = 24;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DITHER_OFF = 2'b00,
    DITHER_PERIOD = 2'b01,
    DITHER_COMPARE = 2'b10,
    DITHER_BOTH = 2'b11
  } dither_mode_t;

  typedef enum logic [1:0] {
    CAP_NONE = 2'b00,
    CAP_EVENT0 = 2'b01,
    CAP_EVENT1 = 2'b10,
    CAP_EVENT2 = 2'b11
  } capture_sel_t;

endpackage

// ==== verilog/timer_unit.sv ====
// Purpose: Timer unit of several slices with capture, shared circular read-back, prescaling and dither.
// Assumes: Module clock equals clk; pins are asynchronous and are filtered by three flops.
// Notes: Zero-wait APB slave; the shared read-back item is chosen at the setup cycle.
//
// Summary of operation
// - Each of three events has an interrupt enable, and a capture caused by that event raises a capture interrupt.
// - Each event has a two-bit route field choosing one of four service request outputs, 00 meaning output 0.
// - The extended read-back enable of a slice only counts while one of its capture selects is nonzero.
// - All slices with extended read-back enabled are read through one shared address.
// - Each shared read returns the next capture register holding new data, walking circularly over slices.
// - The master clock of all timers is either the module clock or an external pin signal.
// - Each slice divides the selected clock by a power of two from 1 up to 32768.
// - Each slice has its own prescaler select so every timer can run at its own rate.
// - External clock use and external count input use are independent of each other.
// - Dither select 00 is off, 01 period, 10 compare and 11 both.
// - Compare dither refines duty resolution and period dither refines switching frequency over time.
// - Pattern inputs from the position interface are sampled on the module clock.
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module timer_unit
  import timer_unit_pkg::*;
#(
  parameter int NS = 4 // Number of slices, 2 to 8
) (
  input wire logic clk, // Module and bus clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic ext_clk_in, // External timer clock pin
  input wire logic [NS*3-1:0] event_in, // Three event pins per slice
  input wire logic [NS-1:0] multichannel_pattern_input, // Pattern from position_interface
  output logic [NS-1:0] pwm_out, // PWM per slice
  output logic [3:0] srv_req, // Service request pulses
  output logic irq // Level interrupt
);

  // ----------------------------------------------------------------
  // Local sizes
  // ----------------------------------------------------------------
  localparam int NREG = NS * 4;
  localparam int PW = $clog2(NREG);
  localparam int NEV = NS * 3;
  localparam int NIN = 1 + NEV + NS;

  // ----------------------------------------------------------------
  // Pin synchronisers and filters
  // ----------------------------------------------------------------
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] filt_q;
  logic [NIN-1:0] prev_q;
  logic [NIN-1:0] agree;
  logic [NIN-1:0] rise;
  logic ext_rise;
  logic [NEV-1:0] ev_rise;
  logic [NS-1:0] pattern;

  assign pin_raw = {multichannel_pattern_input, event_in, ext_clk_in};

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign agree = ~(s2_q ^ s3_q);

  // Filtered level and its previous value for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_q <= '0;
      prev_q <= '0;
    end else begin
      filt_q <= (agree & s3_q) | (~agree & filt_q);
      prev_q <= filt_q;
    end
  end

  assign rise = filt_q & ~prev_q;
  assign ext_rise = rise[0];
  assign ev_rise = rise[NEV:1];
  assign pattern = filt_q[NIN-1:NEV+1];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic setup;
  logic access;
  logic wr;
  logic rd_access;
  logic in_page;
  logic [2:0] sidx;
  logic [2:0] soff;
  logic slice_ok;
  logic hit_glob;
  logic hit_shared;
  logic mapped;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd_access = access & ~pwrite;
  assign in_page = (paddr[11:8] == SLICE_PAGE) && (paddr[1:0] == 2'b00);
  assign sidx = paddr[7:5];
  assign soff = paddr[4:2];
  assign slice_ok = in_page && (int'(sidx) < NS) && (soff <= SL_FULL);
  assign hit_shared = (paddr == SHARED_READ_OFS);
  assign hit_glob = (paddr == GLOBAL_CTRL_OFS) || (paddr == IRQ_STATUS_OFS) || (paddr == IRQ_CLEAR_OFS)
                 || (paddr == IRQ_ENABLE_OFS) || hit_shared;
  assign mapped = hit_glob || slice_ok;
  // Zero wait states; error only on unmapped words
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // ----------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------
  logic clk_src_ext_q;
  logic [NEV-1:0] status_q;
  logic [NEV-1:0] irq_en_q;
  logic [NEV-1:0] cap_irq;
  logic [NEV-1:0] status_clr;

  assign status_clr = (wr && paddr == IRQ_CLEAR_OFS) ? pwdata[NEV-1:0] : '0;

  // Clock source and interrupt enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_src_ext_q <= 1'b0;
      irq_en_q <= IRQ_ENABLE_RESET[NEV-1:0];
    end else begin
      if (wr && paddr == GLOBAL_CTRL_OFS) begin
        clk_src_ext_q <= pwdata[0];
      end
      if (wr && paddr == IRQ_ENABLE_OFS) begin
        irq_en_q <= pwdata[NEV-1:0];
      end
    end
  end

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~status_clr) | cap_irq;
    end
  end

  assign irq = |(status_q & irq_en_q);

  // ----------------------------------------------------------------
  // Module tick: system clock every cycle or external pin edge
  // ----------------------------------------------------------------
  logic mod_tick;

  assign mod_tick = clk_src_ext_q ? ext_rise : 1'b1;

  // ----------------------------------------------------------------
  // Shared read-back search and bookkeeping
  // ----------------------------------------------------------------
  logic [NREG-1:0] full_all;
  logic [NREG*TIMER_W-1:0] cap_all;
  logic [NS-1:0] elig;
  logic [PW-1:0] ptr_q;
  logic [PW-1:0] hit_idx;
  logic hit;
  logic [PW-1:0] sr_idx_q;
  logic sr_hit_q;
  logic sr_done;
  int cand;

  // Search from the register after the last one returned, circularly
  always_comb begin
    cand = 0;
    hit = 1'b0;
    hit_idx = '0;
    for (int k = NREG; k >= 1; k--) begin
      cand = (int'(ptr_q) + k) % NREG;
      if (full_all[cand] && elig[cand / 4]) begin
        hit = 1'b1;
        hit_idx = PW'(cand);
      end
    end
  end

  // Item fixed at setup so the returned data and the cleared flag match
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_idx_q <= '0;
      sr_hit_q <= 1'b0;
    end else if (setup && !pwrite && hit_shared) begin
      sr_idx_q <= hit_idx;
      sr_hit_q <= hit;
    end
  end

  assign sr_done = rd_access && hit_shared && sr_hit_q;

  // Pointer moves only past what was really returned, so nothing is skipped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ptr_q <= PW'(NREG - 1);
    end else if (sr_done) begin
      ptr_q <= sr_idx_q;
    end
  end

  // ----------------------------------------------------------------
  // Timer slices
  // ----------------------------------------------------------------
  logic [NS*32-1:0] srd_all;
  logic [NS*6-1:0] route_all;

  function automatic logic [3:0] bitrev4(input logic [3:0] v);
    bitrev4 = {v[0], v[1], v[2], v[3]};
  endfunction

  for (genvar s = 0; s < NS; s++) begin : g_slice
    logic [31:0] ctrl_q;
    logic [15:0] period_q;
    logic [15:0] compare_q;
    logic [3:0] dval_q;
    logic [TIMER_W-1:0] cnt_q;
    logic [14:0] pre_q;
    logic [3:0] dith_q;
    logic [1:0] wp_q;
    logic [TIMER_W-1:0] cap_q [4];
    logic [3:0] full_q;
    logic pwm_q;
    logic sel_wr;
    logic run;
    logic extended_readback_enable;
    capture_sel_t capture0_select;
    capture_sel_t capture1_select;
    logic cnt_ext;
    dither_mode_t dither_select;
    logic [3:0] prescaler_select;
    logic [2:0] ev_irq_en;
    logic [15:0] div_onehot;
    logic [14:0] pre_mask;
    logic pre_tick;
    logic cnt_tick;
    logic [2:0] ev;
    logic c0;
    logic c1;
    logic dp;
    logic dc;
    logic [16:0] period_eff;
    logic [16:0] compare_eff;
    logic wrap;
    logic [3:0] full_set;
    logic [3:0] full_clr;
    logic [31:0] srd;

    assign sel_wr = wr && slice_ok && (int'(sidx) == s);
    assign run = ctrl_q[CTRL_RUN];
    assign extended_readback_enable = ctrl_q[CTRL_ECM];
    assign capture0_select = capture_sel_t'(ctrl_q[CTRL_CAP0 +: 2]);
    assign capture1_select = capture_sel_t'(ctrl_q[CTRL_CAP1 +: 2]);
    assign cnt_ext = ctrl_q[CTRL_CNT_EXT];
    assign dither_select = dither_mode_t'(ctrl_q[CTRL_DITH +: 2]);
    assign prescaler_select = ctrl_q[CTRL_PRESCALER_SELECT +: 4];
    assign ev_irq_en = ctrl_q[CTRL_IRQEN +: 3];
    assign route_all[s*6 +: 6] = ctrl_q[CTRL_ROUTE +: 6];
    assign ev = ev_rise[s*3 +: 3];

    // Capture mode needed before shared read-back counts
    assign elig[s] = extended_readback_enable
                  && (capture0_select != CAP_NONE || capture1_select != CAP_NONE);

    // Software-written slice registers
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        ctrl_q <= CTRL_RESET;
        period_q <= PERIOD_RESET;
        compare_q <= COMPARE_RESET;
        dval_q <= DITHER_RESET;
      end else if (sel_wr) begin
        if (soff == SL_CTRL) ctrl_q <= pwdata & CTRL_MASK;
        if (soff == SL_PERIOD) period_q <= pwdata[15:0];
        if (soff == SL_COMPARE) compare_q <= pwdata[15:0];
        if (soff == SL_DITHER) dval_q <= pwdata[3:0];
      end
    end

    // Power-of-two divide, 1 to 32768, own select per slice
    assign div_onehot = 16'h0001 << prescaler_select;
    assign pre_mask = 15'(div_onehot - 16'h0001);
    assign pre_tick = mod_tick && ((pre_q & pre_mask) == pre_mask);
    // Count input path does not look at the clock source select
    assign cnt_tick = cnt_ext ? ev[2] : pre_tick;

    // Dither adds one count in a spread pattern of sixteen periods
    assign dp = dither_select[0] && (bitrev4(dith_q) < dval_q);
    assign dc = dither_select[1] && (bitrev4(dith_q) < dval_q);
    assign period_eff = {1'b0, period_q} + {16'h0000, dp};
    assign compare_eff = {1'b0, compare_q} + {16'h0000, dc};
    assign wrap = ({1'b0, cnt_q} >= period_eff);

    // Prescaler, counter and dither sequence
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        pre_q <= '0;
        cnt_q <= '0;
        dith_q <= '0;
        pwm_q <= 1'b0;
      end else begin
        if (mod_tick) pre_q <= pre_q + 15'h0001;
        if (run && cnt_tick) begin
          cnt_q <= wrap ? '0 : cnt_q + 16'h0001;
          if (wrap) dith_q <= dith_q + 4'h1;
        end
        pwm_q <= run && ({1'b0, cnt_q} < compare_eff) && pattern[s];
      end
    end

    assign pwm_out[s] = pwm_q;

    // Capture triggers: select 01..11 names event 0..2
    assign c0 = (capture0_select != CAP_NONE) && ev[capture0_select - 2'b01];
    assign c1 = (capture1_select != CAP_NONE) && ev[capture1_select - 2'b01];
    assign full_set = {c1 & wp_q[1], c1 & ~wp_q[1], c0 & wp_q[0], c0 & ~wp_q[0]};
    assign full_clr = (sr_done && int'(sr_idx_q[PW-1:2]) == s) ? (4'h1 << sr_idx_q[1:0]) : 4'h0;

    // Capture store; each select alternates over its own pair
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        wp_q <= 2'b00;
        full_q <= 4'h0;
        for (int j = 0; j < 4; j++) cap_q[j] <= '0;
      end else begin
        for (int j = 0; j < 4; j++) begin
          if (full_set[j]) cap_q[j] <= cnt_q;
        end
        wp_q <= wp_q ^ {c1, c0};
        full_q <= (full_q & ~full_clr) | full_set;
      end
    end

    for (genvar j = 0; j < 4; j++) begin : g_cap
      assign cap_all[(s*4+j)*TIMER_W +: TIMER_W] = cap_q[j];
    end
    assign full_all[s*4 +: 4] = full_q;

    // Capture interrupt when the enabled event drove a capture
    for (genvar e = 0; e < 3; e++) begin : g_ev
      assign cap_irq[s*3+e] = ev[e] && ev_irq_en[e]
                           && (capture0_select == 2'(e + 1) || capture1_select == 2'(e + 1));
    end

    // Slice read word
    always_comb begin
      srd = 32'h0000_0000;
      unique case (soff)
        SL_CTRL: srd = ctrl_q;
        SL_PERIOD: srd = {16'h0000, period_q};
        SL_COMPARE: srd = {16'h0000, compare_q};
        SL_DITHER: srd = {28'h0000000, dval_q};
        SL_TIMER: srd = {16'h0000, cnt_q};
        SL_FULL: srd = {28'h0000000, full_q};
        default: srd = 32'h0000_0000;
      endcase
    end
    assign srd_all[s*32 +: 32] = srd;
  end

  // ----------------------------------------------------------------
  // Service request routing
  // ----------------------------------------------------------------
  logic [3:0] srv_d;
  logic [3:0] srv_q;

  // Each event's capture interrupt goes to the output its route field names
  always_comb begin
    srv_d = 4'h0;
    for (int i = 0; i < NEV; i++) begin
      if (cap_irq[i]) srv_d[route_all[i*2 +: 2]] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) srv_q <= 4'h0;
    else srv_q <= srv_d;
  end

  assign srv_req = srv_q;

  // ----------------------------------------------------------------
  // Read data, latched at the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] shared_word;
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  assign shared_word = hit ? ((32'h1 << SR_VALID_POS) | (32'(hit_idx >> 2) << SR_SLICE_POS)
                            | (32'(hit_idx[1:0]) << SR_REG_POS)
                            | 32'(cap_all[int'(hit_idx)*TIMER_W +: TIMER_W])) : 32'h0000_0000;

  assign rd_mux = slice_ok ? srd_all[int'(sidx)*32 +: 32]
                : (paddr == GLOBAL_CTRL_OFS) ? {31'h00000000, clk_src_ext_q}
                : (paddr == IRQ_STATUS_OFS) ? 32'(status_q)
                : (paddr == IRQ_ENABLE_OFS) ? 32'(irq_en_q)
                : hit_shared ? shared_word
                : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) prdata_q <= 32'h0000_0000;
    else if (setup && !pwrite) prdata_q <= rd_mux;
  end

  assign prdata = prdata_q;

endmodule

// ==== dv/timer_unit_checker.sv ====
// Purpose: Port-level assertions for the timer unit
// Assumes: One clock, reset asynchronous and active high
// Notes: Bound to the design from the bench top file
`timescale 1ns/100ps
module timer_unit_checker #(
  parameter int NS = 4
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic ext_clk_in, // External clock
  input wire logic [NS*3-1:0] event_in, // Event pins
  input wire logic [NS-1:0] multichannel_pattern_input, // Pattern
  input wire logic [NS-1:0] pwm_out, // PWM
  input wire logic [3:0] srv_req, // Requests
  input wire logic irq // Interrupt
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic wr_acc_q;
  // Write access of the previous cycle, cause of enable-driven irq
  always_ff @(posedge clk or posedge rst) begin
    if (rst) wr_acc_q <= 1'b0;
    else wr_acc_q <= psel && penable && pwrite;
  end
  sequence rd_acc;
    psel && penable && !pwrite;
  endsequence
  sequence quiet_ev;
    (event_in == '0) [*8];
  endsequence
  sequence pat_low;
    !multichannel_pattern_input[3] [*8];
  endsequence
  AST_READY: assert property (pready)
    else $error("ready low");
  AST_RD_HOLD: assert property (rd_acc |=> $stable(prdata))
    else $error("read data moved after access");
  AST_ERR_SETUP: assert property (psel && !penable |-> !pslverr)
    else $error("error outside access phase");
  AST_ERR_ZERO: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("refused read not zero");
  AST_SRV_PULSE: assert property (srv_req != 4'h0 |=> (srv_req & $past(srv_req)) == 4'h0)
    else $error("request longer than one cycle");
  AST_EV_QUIET: assert property (quiet_ev |-> srv_req == 4'h0)
    else $error("request without event");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> srv_req != 4'h0 || wr_acc_q)
    else $error("irq rose without cause");
  AST_PWM_GATE: assert property (pat_low |-> !pwm_out[3])
    else $error("pwm high with pattern low");
endmodule

// ==== dv/position_interface_model.sv ====
// Purpose: Position interface and event source model
// Assumes: Pins change just after a rising clk edge
// Notes: Pattern idles high so the outputs may toggle
`timescale 1ns/100ps
module position_interface_model #(
  parameter int NS = 4
) (
  input wire logic clk, // Module clock
  output logic [NS*3-1:0] event_in, // Event pins
  output logic [NS-1:0] pattern // Pattern per slice
);
  initial begin
    event_in = '0;
    pattern = '1;
  end
  // Rise held long enough to pass the pin filter
  task automatic pulse(input int idx);
    @(posedge clk);
    event_in[idx] <= 1'b1;
    repeat (8) @(posedge clk);
    event_in[idx] <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // Pattern level, held until changed
  task automatic set_pattern(input logic [NS-1:0] p);
    @(posedge clk);
    pattern <= p;
  endtask
endmodule

// ==== dv/timer_unit_tb.sv ====
// Purpose: Self-checking bench for the timer unit
// Assumes: Zero-wait bus slave, module clock equal to clk
// Notes: Timer spans carry one count of slack for phase, two with the external clock
`timescale 1ns/100ps
module timer_unit_tb;
  import timer_unit_pkg::*;
  localparam int NS = 4;
  logic clk, rst, psel, penable, pwrite, pslverr, pready, irq, err, ext_run;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NS*3-1:0] event_in;
  logic [NS-1:0] multichannel_pattern_input, pwm_out;
  logic [3:0] srv_req;
  logic [2:0] ext_cnt;
  logic [15:0] prev;
  wire ext_clk_in = ext_run & ext_cnt[2];
  int fails, checks, cyc, e, d2, d3, wmin, wmax, pmin, pmax;
  int srv_n[4];
  int b[4];
  timer_unit #(.NS(NS)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clk_in(ext_clk_in), .event_in(event_in), .multichannel_pattern_input(multichannel_pattern_input),
    .pwm_out(pwm_out), .srv_req(srv_req), .irq(irq));
  position_interface_model #(.NS(NS)) pos (.clk(clk), .event_in(event_in),
    .pattern(multichannel_pattern_input));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ----------
  // Monitors and hang guard
  // ----------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    ext_cnt <= ext_cnt + 3'h1;
    for (int j = 0; j < 4; j++) if (srv_req[j] === 1'b1) srv_n[j]++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // ----------
  // Bus access, held until ready
  // ----------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [11:0] sa(input int s, input logic [2:0] w);
    return {SLICE_PAGE, 3'(s), w, 2'b00};
  endfunction
  function automatic logic [31:0] near(input int v, input int x, input int t);
    return {31'h0, v >= x - t && v <= x + t};
  endfunction
  // Request counts since the last look; -1 expects none
  task automatic srv_chk(input int r);
    for (int j = 0; j < 4; j++) chk(32'(srv_n[j] - b[j]), 32'(j == r));
    b = srv_n;
  endtask
  // Timer advance of slices 2 and 3 over a fixed 326-cycle span
  task automatic span();
    logic [15:0] a2, a3;
    apb(1'b0, sa(2, SL_TIMER), 32'h0);
    a2 = rd[15:0];
    apb(1'b0, sa(3, SL_TIMER), 32'h0);
    a3 = rd[15:0];
    repeat (320) @(posedge clk);
    apb(1'b0, sa(2, SL_TIMER), 32'h0);
    d2 = int'(rd[15:0] - a2);
    apb(1'b0, sa(3, SL_TIMER), 32'h0);
    d3 = int'(rd[15:0] - a3);
  endtask
  task automatic upd(input int v, inout int mn, inout int mx);
    mn = (v < mn) ? v : mn;
    mx = (v > mx) ? v : mx;
  endtask
  // Pulse widths and rise spacing of slice 3, partial pulses skipped
  task automatic measure();
    logic last, hi;
    int w, p;
    last = 1'b1;
    w = -999;
    p = -999;
    wmin = 999;
    wmax = 0;
    pmin = 999;
    pmax = 0;
    repeat (40) @(posedge clk);
    repeat (400) begin
      @(posedge clk);
      hi = (pwm_out[3] === 1'b1);
      if (hi && !last) begin
        if (p > 0) upd(p, pmin, pmax);
        p = 0;
        w = 0;
      end
      if (!hi && last && w > 0) upd(w, wmin, wmax);
      w = w + hi;
      p++;
      last = hi;
    end
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ext_run = 1'b0;
    ext_cnt = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rdc(IRQ_ENABLE_OFS, IRQ_ENABLE_RESET);
    rdc(sa(0, SL_PERIOD), {16'h0, PERIOD_RESET});
    rdc(sa(0, SL_CTRL), CTRL_RESET);
    rdc(12'h7F0, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Each of the four routes once, from events 0, 1, 2, 0 of slice 1, then raise, mask and clear
    for (int i = 0; i < 4; i++) begin
      e = i % 3;
      wr(sa(1, SL_CTRL), 32'h1 | (32'(e + 1) << CTRL_CAP0) | (32'h1 << (CTRL_IRQEN + e)) | (32'(i) << (CTRL_ROUTE + 2 * e)));
      pos.pulse(3 + e);
      srv_chk(i);
      rdc(IRQ_STATUS_OFS, 32'h8 << e);
      chk({31'h0, irq}, 32'h0);
      wr(IRQ_ENABLE_OFS, 32'h8 << e);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(IRQ_CLEAR_OFS, 32'h8 << e);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    wr(sa(1, SL_CTRL), 32'h5);
    pos.pulse(3);
    srv_chk(-1);
    rdc(IRQ_STATUS_OFS, 32'h0);
    // Slice 2 holds data but leaves capture mode
    wr(sa(2, SL_CTRL), 32'h5);
    pos.pulse(6);
    wr(sa(2, SL_CTRL), 32'h3);
    wr(sa(0, SL_CTRL), 32'h27);
    pos.pulse(0);
    pos.pulse(0);
    pos.pulse(1);
    pos.pulse(1);
    prev = 16'h0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, SHARED_READ_OFS, 32'h0);
      chk({16'h0, rd[31:16]}, 32'h100 + k);
      chk({31'h0, rd[15:0] > prev}, 32'h1);
      prev = rd[15:0];
    end
    rdc(SHARED_READ_OFS, 32'h0);
    pos.pulse(0);
    apb(1'b0, SHARED_READ_OFS, 32'h0);
    chk({16'h0, rd[31:16]}, 32'h100);
    // Rates per slice
    wr(sa(0, SL_CTRL), 32'h0);
    wr(sa(2, SL_CTRL), 32'h1);
    wr(sa(3, SL_CTRL), 32'h1 | (32'h4 << CTRL_PRESCALER_SELECT));
    span();
    chk(near(d2, 326, 1), 32'h1);
    chk(near(d3, 20, 1), 32'h1);
    // External clock; slice 3 divides by two, while slice 1 still runs at divide by one
    wr(sa(2, SL_CTRL), 32'h0);
    wr(sa(3, SL_CTRL), 32'h1 | (32'h1 << CTRL_PRESCALER_SELECT));
    wr(GLOBAL_CTRL_OFS, 32'h1);
    ext_run <= 1'b1;
    span();
    chk(near(d3, 20, 2), 32'h1);
    ext_run <= 1'b0;
    repeat (10) @(posedge clk);
    span();
    chk(32'(d3), 32'h0);
    wr(GLOBAL_CTRL_OFS, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(sa(s, SL_CTRL), 32'h41);
      apb(1'b0, sa(s, SL_TIMER), 32'h0);
      prev = rd[15:0];
      pos.pulse(s * 3 + 2);
      rdc(sa(s, SL_TIMER), {16'h0, prev + 16'h1});
    end
    // Dither modes; period written while dither is off
    wr(sa(3, SL_PERIOD), 32'h9);
    wr(sa(3, SL_COMPARE), 32'h4);
    wr(sa(3, SL_DITHER), 32'h8);
    for (int m = 0; m < 4; m++) begin
      wr(sa(3, SL_CTRL), 32'h1 | (32'(m) << CTRL_DITH));
      measure();
      chk(32'(wmax - wmin), 32'(m >> 1));
      chk(32'(pmax - pmin), 32'(m & 1));
    end
    pos.set_pattern('0);
    measure();
    chk(32'(wmax), 32'h0);
    finish_test();
  end
endmodule
bind timer_unit timer_unit_checker #(.NS(NS)) u_chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ext_clk_in(ext_clk_in), .event_in(event_in), .multichannel_pattern_input(multichannel_pattern_input),
  .pwm_out(pwm_out), .srv_req(srv_req), .irq(irq));
